// *** bench/dsp_operand_address_generation_tb.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module dsp_operand_address_generation_tb;
    import oag_pkg::*;
    logic sys_clk = 0, reset_n = 0, op_valid = 0, dual_valid = 0, wr_en = 0;
    logic x_indexed = 0, y_indexed = 0, x_dmod_down = 0, y_dmod_down = 0;
    oag_mode_t op_mode = OAG_NOP;
    oag_dmod_t x_dmod = OAG_DPOST0, y_dmod = OAG_DPOST0;
    logic [3:0] pointer_reg = 0, offset_select_reg = 0, x_ptr_sel = 0, y_ptr_sel = 0, wr_sel = 0;
    logic [15:0] op_field = 0, wr_data = 0, ea, literal_out, x_addr, y_addr, p, q, a, b, f;
    logic signed [15:0] mod_const = 0;
    logic ea_valid, no_operand, dual_ok, dual_error;
    logic [2:0] kq[$];
    logic [31:0] vq[$];
    logic [31:0] got;
    logic [15:0] x_rd, y_rd;
    logic mem_due = 0;
    logic [31:0] mem_exp;
    int bad_count = 0, n_tests = 0;
    oag_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_mode(op_mode), .pointer_reg(pointer_reg), .offset_select_reg(offset_select_reg),
        .op_field(op_field), .mod_const(mod_const), .dual_valid(dual_valid),
        .x_ptr_sel(x_ptr_sel), .y_ptr_sel(y_ptr_sel), .x_indexed(x_indexed),
        .y_indexed(y_indexed), .x_dmod(x_dmod), .y_dmod(y_dmod), .x_dmod_down(x_dmod_down),
        .y_dmod_down(y_dmod_down), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
        .ea_valid(ea_valid), .ea(ea), .literal_out(literal_out), .no_operand(no_operand),
        .dual_ok(dual_ok), .x_addr(x_addr), .y_addr(y_addr), .dual_error(dual_error));
    oag_xy_mem mem (.sys_clk(sys_clk), .dual_ok(dual_ok), .x_addr(x_addr), .y_addr(y_addr),
        .x_rd(x_rd), .y_rd(y_rd));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic note(input logic [2:0] k, input logic [31:0] v);
        kq.push_back(k);
        vq.push_back(v);
    endtask
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        @(negedge sys_clk);
        {op_valid, dual_valid, wr_en, wr_sel, wr_data} = {3'b001, s, d};
        @(negedge sys_clk);
        wr_en = 0;
    endtask
    // kinds: 0 ea, 1 literal, 2 no operand
    task automatic op(input oag_mode_t m, input logic [3:0] r, input logic [15:0] fd,
        input logic signed [15:0] c, input logic [2:0] k, input logic [15:0] ev);
        @(negedge sys_clk);
        {op_valid, dual_valid, op_mode, pointer_reg, op_field, mod_const, offset_select_reg} =
            {2'b10, m, r, fd, c, 4'h5};
        note(k, (k == 2) ? 32'h1 : {16'h0, ev});
    endtask
    // kinds: 3 addresses, 4 refused
    task automatic dl(input logic [3:0] xs, ys, input logic xi, yi, input oag_dmod_t xm, ym,
        input logic dn, input logic [2:0] k, input logic [15:0] ex, ey);
        @(negedge sys_clk);
        {op_valid, dual_valid, x_ptr_sel, y_ptr_sel, x_indexed, y_indexed} = {2'b01, xs, ys, xi, yi};
        {x_dmod, y_dmod, x_dmod_down, y_dmod_down, offset_select_reg} = {xm, ym, dn, dn, 4'h5};
        note(k, (k == 3) ? {ex, ey} : 32'h1);
    endtask
    // scoreboard: oldest note against each result pulse
    always @(negedge sys_clk) begin
        // memory answer one cycle after each accepted dual read
        if (mem_due) begin
            n_tests++;
            if ({x_rd, y_rd} !== mem_exp) begin
                bad_count++;
                $display("FAIL %0t memory answer %h unexpected", $time, {x_rd, y_rd});
            end
        end
        mem_due = (dual_ok === 1'b1);
        mem_exp = {~x_addr, y_addr[7:0], y_addr[15:8]};
        if (reset_n && (ea_valid | no_operand | dual_ok | dual_error) === 1'b1) begin
            n_tests++;
            case (kq[0])
                0: got = {16'h0, ea};
                1: got = {16'h0, literal_out};
                2: got = {31'h0, no_operand};
                3: got = {x_addr, y_addr};
                default: got = {31'h0, dual_error};
            endcase
            if (kq.size() == 0 || got !== vq[0]) begin
                bad_count++;
                $display("FAIL %0t result %h unexpected", $time, got);
            end
            if (kq.size() != 0) begin
                void'(kq.pop_front());
                void'(vq.pop_front());
            end
        end
    end
    task automatic finish_test;
        if (kq.size() != 0) bad_count++;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test;
    end
    initial begin
        p = 16'($urandom(32'h81F56EAB));
        p = 16'($urandom) & 16'h7FFE | 16'h0100;
        q = 16'($urandom) & 16'h00FE;
        f = 16'($urandom);
        a = 16'($urandom) & 16'h3FFE;
        b = 16'($urandom) & 16'h3FFE | 16'h4000;
        repeat (8) @(negedge sys_clk);
        reset_n = 1;
        wr(4'h3, p);
        wr(4'h5, q);
        op(OAG_INDIRECT, 4'h3, f, 0, 0, p);
        op(OAG_POST_MOD, 4'h3, f, 2, 0, p);
        op(OAG_INDIRECT, 4'h3, f, 0, 0, p + 16'h2);
        op(OAG_PRE_MOD, 4'h3, f, -4, 0, p - 16'h2);
        op(OAG_DIRECT, 4'h3, f, 0, 0, f);
        op(OAG_INDEXED, 4'h3, f, 0, 0, p - 16'h2 + q);
        op(OAG_LIT_OFS, 4'h3, 16'h0040, 0, 0, p + 16'h003E);
        for (int i = 1; i < 16; i++) begin
            op(OAG_BITREV, 4'h0, 16'(i), 0, 0, {12'h0, i[0], i[1], i[2], i[3]});
        end
        op(OAG_LIT8, 4'h0, 16'hA5C3, 0, 1, 16'h00C3);
        op(OAG_LIT16, 4'h0, 16'hA5C3, 0, 1, 16'hA5C3);
        op(OAG_BRANCH, 4'h0, 16'hFF80, 0, 1, 16'hFF80);
        op(OAG_INT_HOLD, 4'h0, 16'hFFFF, 0, 1, 16'h3FFF);
        op(OAG_IMPLIED, 4'h0, f, 0, 2, 0);
        op(OAG_NOP, 4'h0, f, 0, 2, 0);
        wr(4'h8, a);
        $display("single operand test done");
        wr(4'hA, b);
        wr(4'h9, a);
        wr(4'hB, b);
        dl(4'h8, 4'hA, 0, 0, OAG_DPOST2, OAG_DPOST4, 0, 3, a, b);
        dl(4'h8, 4'hA, 0, 0, OAG_DPOST6, OAG_DPOST4, 1, 3, a + 16'h2, b + 16'h4);
        dl(4'h9, 4'hB, 1, 1, OAG_DPOST0, OAG_DPOST0, 0, 3, a + q, b + q);
        dl(4'hA, 4'h8, 0, 0, OAG_DPOST2, OAG_DPOST2, 0, 4, 0, 0);
        dl(4'h3, 4'hB, 0, 0, OAG_DPOST2, OAG_DPOST2, 0, 4, 0, 0);
        dl(4'h8, 4'hA, 1, 0, OAG_DPOST0, OAG_DPOST0, 0, 4, 0, 0);
        dl(4'h9, 4'hB, 1, 1, OAG_DPOST2, OAG_DPOST0, 0, 4, 0, 0);
        dl(4'h8, 4'hA, 0, 0, OAG_DPOST0, OAG_DPOST0, 0, 3, a - 16'h4, b);
        @(negedge sys_clk);
        dual_valid = 0;
        repeat (4) @(negedge sys_clk);
        $display("dual operand test done");
        finish_test;
    end
endmodule
`default_nettype wire

// *** bench/oag_xy_mem.sv ***
// far-side data memory model answering dual reads
`timescale 1ns/1ps
`default_nettype none
module oag_xy_mem (
    input wire logic sys_clk,
    input wire logic dual_ok,
    input wire logic [15:0] x_addr,
    input wire logic [15:0] y_addr,
    output logic [15:0] x_rd,
    output logic [15:0] y_rd
);
    // data is made from the read address so stale values from another address never look right
    always_ff @(posedge sys_clk) begin
        if (dual_ok) begin
            x_rd <= ~x_addr;
            y_rd <= {y_addr[7:0], y_addr[15:8]};
        end
    end
endmodule
`default_nettype wire

// *** logic/oag_core.sv ***
// operand effective-address generator with pointer register file
`timescale 1ns/1ps
`default_nettype none
module oag_core (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire oag_pkg::oag_mode_t op_mode,
    input wire logic [3:0] pointer_reg,
    input wire logic [3:0] offset_select_reg,
    input wire logic [15:0] op_field,
    input wire logic signed [15:0] mod_const,
    input wire logic dual_valid,
    input wire logic [3:0] x_ptr_sel,
    input wire logic [3:0] y_ptr_sel,
    input wire logic x_indexed,
    input wire logic y_indexed,
    input wire oag_pkg::oag_dmod_t x_dmod,
    input wire oag_pkg::oag_dmod_t y_dmod,
    input wire logic x_dmod_down,
    input wire logic y_dmod_down,
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [15:0] wr_data,
    output logic ea_valid,
    output logic [15:0] ea,
    output logic [15:0] literal_out,
    output logic no_operand,
    output logic dual_ok,
    output logic [15:0] x_addr,
    output logic [15:0] y_addr,
    output logic dual_error
);
    import oag_pkg::*;

    logic [15:0] regs [NUM_REGS];
    logic [15:0] next_ea;
    logic [15:0] next_lit;
    logic [15:0] next_x;
    logic [15:0] next_y;
    logic legal_dual;
    logic [15:0] base;
    logic [15:0] ofs;

    // bit mirror of the low four bits
    function automatic logic [15:0] bitrev4(input logic [15:0] v);
        bitrev4 = {12'h000, v[0], v[1], v[2], v[3]};
    endfunction

    // post-modify step for dual operand reads
    function automatic logic [15:0] dstep(input oag_dmod_t m, input logic dn);
        logic [15:0] s;
        s = {13'h0000, m, 1'b0};
        dstep = dn ? (16'h0000 - s) : s;
    endfunction

    assign base = regs[pointer_reg];
    assign ofs = regs[offset_select_reg]; // one shared select R07

    // single-operand address formation
    always_comb begin
        next_ea = 16'h0000;
        next_lit = 16'h0000;
        case (op_mode)
            OAG_DIRECT: next_ea = op_field; // R01
            OAG_INDIRECT: next_ea = base; // R02
            OAG_POST_MOD: next_ea = base; // R03
            OAG_PRE_MOD: next_ea = base + mod_const; // R04
            OAG_INDEXED: next_ea = base + ofs; // R05 R08
            OAG_LIT_OFS: next_ea = base + op_field; // R06
            OAG_LIT8: next_lit = {8'h00, op_field[7:0]}; // R08
            OAG_LIT16: next_lit = op_field; // R08
            OAG_BRANCH: next_lit = op_field; // R14
            OAG_INT_HOLD: next_lit = {2'b00, op_field[INTERRUPT_HOLD_OP_W-1:0]}; // R15
            OAG_BITREV: next_ea = bitrev4(op_field); // R17
            default: next_ea = 16'h0000; // R16
        endcase
    end

    // pointer legality for dual reads
    always_comb begin
        legal_dual = (x_ptr_sel == X_PTR_A || x_ptr_sel == X_PTR_B) // R09 R10
            && (y_ptr_sel == Y_PTR_A || y_ptr_sel == Y_PTR_B)
            && (!x_indexed || x_ptr_sel == X_PTR_B) // R12
            && (!y_indexed || y_ptr_sel == Y_PTR_B)
            && !(x_indexed && x_dmod != OAG_DPOST0) // R13
            && !(y_indexed && y_dmod != OAG_DPOST0);
        next_x = x_indexed ? regs[x_ptr_sel] + ofs : regs[x_ptr_sel];
        next_y = y_indexed ? regs[y_ptr_sel] + ofs : regs[y_ptr_sel];
    end

    // single-operand answer registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ea_valid <= 1'b0;
            ea <= 16'h0000;
            literal_out <= 16'h0000;
            no_operand <= 1'b0;
        end else begin
            ea_valid <= op_valid;
            no_operand <= op_valid && (op_mode == OAG_NOP || op_mode == OAG_IMPLIED); // R16
            if (op_valid) begin
                ea <= next_ea;
                literal_out <= next_lit;
            end
        end
    end

    // dual-operand answer registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dual_ok <= 1'b0;
            dual_error <= 1'b0;
            x_addr <= 16'h0000;
            y_addr <= 16'h0000;
        end else begin
            dual_ok <= dual_valid && legal_dual;
            dual_error <= dual_valid && !legal_dual;
            if (dual_valid && legal_dual) begin
                x_addr <= next_x; // R10
                y_addr <= next_y; // R10
            end
        end
    end

    // pointer file with same-instruction write-back
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    regs[gi] <= RESET_PTR;
                end else if (dual_valid && legal_dual && x_ptr_sel == gi && !x_indexed) begin
                    regs[gi] <= regs[gi] + dstep(x_dmod, x_dmod_down); // R13 R18
                end else if (dual_valid && legal_dual && y_ptr_sel == gi && !y_indexed) begin
                    regs[gi] <= regs[gi] + dstep(y_dmod, y_dmod_down); // R13 R18
                end else if (op_valid && pointer_reg == gi
                    && (op_mode == OAG_POST_MOD || op_mode == OAG_PRE_MOD)) begin
                    regs[gi] <= regs[gi] + mod_const; // R03 R04 R18
                end else if (wr_en && wr_sel == gi) begin
                    regs[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // checks
    chk_direct_ea: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
        op_valid && op_mode == OAG_DIRECT |=> ea_valid && ea == $past(op_field))
        else $error("direct address wrong");
    chk_indirect_ea: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
        op_valid && op_mode == OAG_INDIRECT |=> ea == $past(base))
        else $error("indirect address wrong");
    chk_post_mod: assert property (@(posedge sys_clk) disable iff (!reset_n) // R03
        op_valid && op_mode == OAG_POST_MOD && !dual_valid
        |=> ea == $past(base) && regs[$past(pointer_reg)] == $past(base + mod_const))
        else $error("post modify wrong");
    chk_pre_mod: assert property (@(posedge sys_clk) disable iff (!reset_n) // R04
        op_valid && op_mode == OAG_PRE_MOD && !dual_valid
        |=> ea == regs[$past(pointer_reg)])
        else $error("pre modify wrong");
    chk_indexed_ea: assert property (@(posedge sys_clk) disable iff (!reset_n) // R05
        op_valid && op_mode == OAG_INDEXED |=> ea == $past(base + ofs))
        else $error("indexed address wrong");
    chk_lit_ofs: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
        op_valid && op_mode == OAG_LIT_OFS |=> ea == $past(base + op_field))
        else $error("literal offset wrong");
    chk_dual_ptrs: assert property (@(posedge sys_clk) disable iff (!reset_n) // R09
        dual_valid && (x_ptr_sel < 4'h8 || y_ptr_sel > 4'hB) |=> dual_error && !dual_ok)
        else $error("bad prefetch pointer accepted");
    chk_dual_idx: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
        dual_valid && x_indexed && x_ptr_sel == X_PTR_A |=> dual_error)
        else $error("indexed via wrong pointer");
    chk_hold_lit: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
        op_valid && op_mode == OAG_INT_HOLD |=> literal_out[15:14] == 2'b00)
        else $error("hold literal too wide");
    chk_bitrev: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
        op_valid && op_mode == OAG_BITREV && op_field[3:0] == 4'h1 |=> ea == 16'h0008)
        else $error("bit reverse wrong");

    // single request taken alone this cycle
    sequence s_single_req;
        op_valid && !dual_valid;
    endsequence

    // dual request accepted this cycle
    sequence s_dual_legal;
        dual_valid && legal_dual;
    endsequence

    // dual request refused this cycle
    sequence s_dual_bad;
        dual_valid && !legal_dual;
    endsequence

    // no request, no result pulse
    chk_valid_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
        !op_valid |=> !ea_valid)
        else $error("spurious address pulse");

    // short literal is zero-extended
    chk_lit8_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
        s_single_req ##0 op_mode == OAG_LIT8 |=> literal_out[15:8] == 8'h00)
        else $error("short literal not extended");

    // long literal passes whole
    chk_lit16_pass: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
        s_single_req ##0 op_mode == OAG_LIT16 |=> literal_out == $past(op_field))
        else $error("long literal wrong");

    // long literal mode leaves the address at zero
    chk_lit_ea_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
        s_single_req ##0 op_mode == OAG_LIT16 |=> ea == 16'h0000)
        else $error("literal mode drove an address");

    // branch target passes whole
    chk_branch_lit: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
        s_single_req ##0 op_mode == OAG_BRANCH |=> literal_out == $past(op_field))
        else $error("branch literal wrong");

    // hold literal keeps its low bits
    chk_hold_value: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
        s_single_req ##0 op_mode == OAG_INT_HOLD
        |=> literal_out[13:0] == $past(op_field[13:0]))
        else $error("hold literal value wrong");

    // no-op reports no operand
    chk_nop_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
        s_single_req ##0 op_mode == OAG_NOP |=> no_operand)
        else $error("no-op flag missing");

    // implied operand reports no operand
    chk_implied_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
        s_single_req ##0 op_mode == OAG_IMPLIED |=> no_operand)
        else $error("implied flag missing");

    // direct operand never flagged
    chk_operand_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
        s_single_req ##0 op_mode == OAG_DIRECT |=> !no_operand)
        else $error("operand wrongly flagged");

    // index two mirrors to four
    chk_bitrev_two: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
        s_single_req ##0 op_mode == OAG_BITREV && op_field[3:0] == 4'h2 |=> ea == 16'h0004)
        else $error("bit reverse of two wrong");

    // index three mirrors to twelve
    chk_bitrev_three: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
        s_single_req ##0 op_mode == OAG_BITREV && op_field[3:0] == 4'h3 |=> ea == 16'h000C)
        else $error("bit reverse of three wrong");

    // direct mode leaves the pointer alone
    chk_direct_keep: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
        s_single_req ##0 op_mode == OAG_DIRECT && !wr_en
        |=> regs[$past(pointer_reg)] == $past(base))
        else $error("direct mode changed pointer");

    // plain indirect leaves the pointer alone
    chk_indirect_keep: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
        s_single_req ##0 op_mode == OAG_INDIRECT && !wr_en
        |=> regs[$past(pointer_reg)] == $past(base))
        else $error("indirect mode changed pointer");

    // pre-modify writes the new pointer back
    chk_pre_wb: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
        s_single_req ##0 op_mode == OAG_PRE_MOD
        |=> regs[$past(pointer_reg)] == $past(base + mod_const))
        else $error("pre modify write-back wrong");

    // accepted dual read answers ok only
    chk_dual_ok: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        s_dual_legal |=> dual_ok && !dual_error)
        else $error("legal dual read refused");

    // y pointer on the x side is refused
    chk_dual_x_side: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        dual_valid && x_ptr_sel == Y_PTR_A |=> dual_error && !dual_ok)
        else $error("y pointer routed to x");

    // x pointer on the y side is refused
    chk_dual_y_side: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        dual_valid && y_ptr_sel == X_PTR_A |=> dual_error && !dual_ok)
        else $error("x pointer routed to y");

    // indexed with a step is refused
    chk_dual_step: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
        dual_valid && x_indexed && x_dmod != OAG_DPOST0 |=> dual_error)
        else $error("indexed dual with step accepted");

    // no dual request, no dual pulse
    chk_dual_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n) // R09
        !dual_valid |=> !dual_ok && !dual_error)
        else $error("spurious dual pulse");

    // refused read leaves addresses alone
    chk_refused_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // R09
        s_dual_bad |=> $stable(x_addr) && $stable(y_addr))
        else $error("refused dual read moved addresses");

    // x address is the pointer before its step
    chk_dual_x_addr: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        s_dual_legal ##0 !x_indexed |=> x_addr == $past(regs[x_ptr_sel]))
        else $error("x prefetch address wrong");

    // x indexed address adds the offset
    chk_dual_x_idx: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
        s_dual_legal ##0 x_indexed |=> x_addr == $past(regs[x_ptr_sel] + ofs))
        else $error("x indexed address wrong");

    // x pointer stepped up by two
    chk_x_step2: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
        s_dual_legal ##0 !x_indexed && x_dmod == OAG_DPOST2 && !x_dmod_down
        |=> regs[$past(x_ptr_sel)] == $past(regs[x_ptr_sel]) + 16'h0002)
        else $error("x step by two wrong");

    // x pointer stepped down by six
    chk_x_step6: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
        s_dual_legal ##0 !x_indexed && x_dmod == OAG_DPOST6 && x_dmod_down
        |=> regs[$past(x_ptr_sel)] == $past(regs[x_ptr_sel]) - 16'h0006)
        else $error("x step down by six wrong");

    // y pointer stepped down by four
    chk_y_step4: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
        s_dual_legal ##0 !y_indexed && y_dmod == OAG_DPOST4 && y_dmod_down
        |=> regs[$past(y_ptr_sel)] == $past(regs[y_ptr_sel]) - 16'h0004)
        else $error("y step down by four wrong");
endmodule
`default_nettype wire

// *** logic/oag_pkg.sv ***
// package for the operand address generator: modes, widths, constants
// What this block does
// (R01) direct mode uses instruction address field
// (R02) indirect uses pointer value unchanged
// (R03) post-modify: access old value, then adjust
// (R04) pre-modify: adjust by signed constant first
// (R05) indexed: pointer plus offset register
// (R06) literal offset: pointer plus instruction literal
// (R07) move source/destination share 4-bit offset select
// (R08) move/accumulator add indexed, 8/16-bit literals
// (R09) dual-operand pointers only registers 8 to 11
// (R10) pointers 8,9 to X; 10,11 to Y
// (R11) software keeps addresses in proper space
// (R12) dual indexed only via pointers 9 and 11
// (R13) dual modes: indirect, indexed, post +2/4/6
// (R14) branch carries 16-bit signed literal
// (R15) interrupt hold carries 14-bit unsigned literal
// (R16) implied operands from opcode; no-op has none
// (R17) bit-reversed address mirrors 4-bit index
// (R18) modified pointer written back same instruction
package oag_pkg;
    localparam int DATA_W = 16;
    localparam int REG_SEL_W = 4;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] X_PTR_A = 4'h8;
    localparam logic [3:0] X_PTR_B = 4'h9;
    localparam logic [3:0] Y_PTR_A = 4'hA;
    localparam logic [3:0] Y_PTR_B = 4'hB;
    localparam logic [15:0] RESET_PTR = 16'h0000;
    localparam int INTERRUPT_HOLD_OP_W = 14;
    typedef enum logic [3:0] {
        OAG_DIRECT = 4'h0,
        OAG_INDIRECT = 4'h1,
        OAG_POST_MOD = 4'h2,
        OAG_PRE_MOD = 4'h3,
        OAG_INDEXED = 4'h4,
        OAG_LIT_OFS = 4'h5,
        OAG_LIT8 = 4'h6,
        OAG_LIT16 = 4'h7,
        OAG_BRANCH = 4'h8,
        OAG_INT_HOLD = 4'h9,
        OAG_IMPLIED = 4'hA,
        OAG_NOP = 4'hB,
        OAG_BITREV = 4'hC
    } oag_mode_t;
    typedef enum logic [1:0] {
        OAG_DPOST0 = 2'h0,
        OAG_DPOST2 = 2'h1,
        OAG_DPOST4 = 2'h2,
        OAG_DPOST6 = 2'h3
    } oag_dmod_t;
endpackage
